// [design/acs_frame_ready.v]
// Serial frame builder and data-ready generator of the converter.
`timescale 1ns/100ps
`include "acs_consts.vh"
module acs_frame_ready #(
  parameter CH = 3,
  parameter DW = 16,
  parameter PW = 10
) (
  // Clock and reset
  input  wire            clk_in,
  input  wire            resetn_in,
  // Serial pins
  input  wire            sclk_in,
  input  wire            cs_n_in,
  input  wire            din_in,
  output wire            dout_out,
  output wire            dout_oe_out,
  // Data-ready pin
  output wire            data_ready_n_out,
  output wire            data_ready_n_oe_out,
  // Configuration
  input  wire [1:0]      word_length_select_in,
  input  wire [1:0]      ready_source_select_in,
  input  wire            ready_drive_select_in,
  input  wire            ready_format_select_in,
  input  wire            global_chop_in,
  input  wire [2:0]      oversampling_ratio_in,
  input  wire [CH-1:0]   channel_enable_in,
  input  wire [CH*PW-1:0] channel_phase_setting_in,
  input  wire            sync_in,
  // Converter side
  input  wire [CH-1:0]   channel_new_in,
  input  wire            conv_valid_in,
  output wire            conv_ready_out,
  input  wire [CH*DW-1:0] conv_data_in,
  // Command side
  input  wire [15:0]     response_in,
  input  wire [15:0]     crc_in,
  input  wire [15:0]     reg_word_in,
  output wire [3:0]      word_index_out,
  output reg  [15:0]     rx_word_out,
  output reg             rx_word_valid_out,
  output reg  [15:0]     cmd_word_out,
  output reg             cmd_valid_out,
  output reg             full_frame_out,
  output reg             reset_cmd_out,
  output reg             data_read_out
);
  // ----------------------------------------------------------------------
  // Reset release and pin sampling
  // ----------------------------------------------------------------------
  localparam [2:0] PIN_IDLE = `ACS_PIN_IDLE;
  reg        rst_s1_r;
  reg        rst_s2_r;
  wire       rst_n = rst_s2_r;
  wire [2:0] pin_raw = {din_in, cs_n_in, sclk_in};
  reg  [2:0] m1_r;
  reg  [2:0] m2_r;
  reg  [2:0] m3_r;
  reg  [2:0] pin_r;

  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end

  // A pin level counts only once the second and third stages agree.
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_pin
      always @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
          m1_r[g]  <= PIN_IDLE[g];
          m2_r[g]  <= PIN_IDLE[g];
          m3_r[g]  <= PIN_IDLE[g];
          pin_r[g] <= PIN_IDLE[g];
        end else begin
          m1_r[g] <= pin_raw[g];
          m2_r[g] <= m1_r[g];
          m3_r[g] <= m2_r[g];
          if (m2_r[g] == m3_r[g]) begin
            pin_r[g] <= m3_r[g];
          end
        end
      end
    end
  endgenerate

  wire sclk = pin_r[0];
  wire cs_n = pin_r[1];
  wire din  = pin_r[2];
  reg  sclk_prev_r;
  reg  cs_prev_r;
  wire sclk_rise = sclk & ~sclk_prev_r & ~cs_n;
  wire sclk_fall = ~sclk & sclk_prev_r & ~cs_n;
  wire cs_fall   = ~cs_n & cs_prev_r;
  wire cs_rise   = cs_n & ~cs_prev_r;

  // ----------------------------------------------------------------------
  // Conversion buffer and frame snapshot
  // ----------------------------------------------------------------------
  wire            buf_valid;
  wire [CH*DW-1:0] buf_data;
  reg  [CH*DW-1:0] frame_data_r;
  reg  [CH-1:0]   frame_en_r;

  acs_buf2 #(
    .W (CH*DW)
  ) u_buf (
    .clk_in        (clk_in),
    .rst_n_in      (rst_n),
    .in_valid_in   (conv_valid_in),
    .in_ready_out  (conv_ready_out),
    .in_data_in    (conv_data_in),
    .out_valid_out (buf_valid),
    .out_ready_in  (cs_fall),
    .out_data_out  (buf_data)
  );

  // ----------------------------------------------------------------------
  // Word formatting
  // ----------------------------------------------------------------------
  reg [1:0]  wl_r;
  reg [5:0]  wbits;
  reg [5:0]  bit_cnt_r;
  reg [3:0]  word_idx_r;
  reg [31:0] tx_sh_r;
  reg [31:0] rx_sh_r;
  reg [31:0] word32;
  reg [15:0] chw;
  reg        dout_r;
  reg        dout_oe_r;
  reg [15:0] cmd_r;
  wire [31:0] rx_full = {rx_sh_r[30:0], din};
  wire [31:0] rx_shr  = rx_full >> (wbits - `ACS_BITS_16);
  wire [3:0]  ch_sel  = word_idx_r - `ACS_IDX_CH_LO;

  assign word_index_out = word_idx_r;

  always @* begin
    case (wl_r)
      `ACS_WL_16: wbits = `ACS_BITS_16;
      `ACS_WL_24: wbits = `ACS_BITS_24;
      default:    wbits = `ACS_BITS_32;
    endcase
  end

  always @* begin
    chw = `ACS_PAD16;
    if (ch_sel < CH) begin
      chw = frame_en_r[ch_sel[1:0]] ?
            frame_data_r[ch_sel[1:0]*DW +: DW] : `ACS_PAD16;
    end
    if (word_idx_r == `ACS_IDX_RESP) begin
      word32 = {response_in, `ACS_PAD16};
    end else if (word_idx_r <= `ACS_IDX_CH_HI) begin
      if (wl_r == `ACS_WL_32_SIGN) begin
        word32 = {{16{chw[15]}}, chw};
      end else begin
        word32 = {chw, `ACS_PAD16};
      end
    end else if (word_idx_r == `ACS_IDX_CRC) begin
      word32 = {crc_in, `ACS_PAD16};
    end else begin
      word32 = {reg_word_in, `ACS_PAD16};
    end
  end

  // ----------------------------------------------------------------------
  // Serial shift engine
  // ----------------------------------------------------------------------
  always @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      sclk_prev_r       <= 1'b0;
      cs_prev_r         <= 1'b1;
      wl_r              <= `ACS_WL_RESET;
      bit_cnt_r         <= 6'h00;
      word_idx_r        <= 4'h0;
      tx_sh_r           <= 32'h0000_0000;
      rx_sh_r           <= 32'h0000_0000;
      dout_r            <= 1'b0;
      dout_oe_r         <= 1'b0;
      cmd_r             <= 16'h0000;
      frame_data_r      <= {CH*DW{1'b0}};
      frame_en_r        <= {CH{1'b0}};
      rx_word_out       <= 16'h0000;
      rx_word_valid_out <= 1'b0;
      cmd_word_out      <= 16'h0000;
      cmd_valid_out     <= 1'b0;
      full_frame_out    <= 1'b0;
      reset_cmd_out     <= 1'b0;
      data_read_out     <= 1'b0;
    end else begin
      sclk_prev_r       <= sclk;
      cs_prev_r         <= cs_n;
      dout_oe_r         <= ~cs_n;
      rx_word_valid_out <= 1'b0;
      cmd_valid_out     <= 1'b0;
      reset_cmd_out     <= 1'b0;
      data_read_out     <= 1'b0;
      if (cs_n) begin
        // Word length changes only take effect between frames.
        wl_r       <= word_length_select_in;
        bit_cnt_r  <= 6'h00;
        word_idx_r <= 4'h0;
      end
      if (cs_fall) begin
        frame_data_r <= buf_valid ? buf_data : {CH*DW{1'b0}};
        frame_en_r   <= buf_valid ? channel_enable_in : {CH{1'b0}};
      end
      if (sclk_rise) begin
        if (bit_cnt_r == 6'h00) begin
          dout_r  <= word32[31];
          tx_sh_r <= {word32[30:0], 1'b0};
        end else begin
          dout_r  <= tx_sh_r[31];
          tx_sh_r <= {tx_sh_r[30:0], 1'b0};
        end
      end
      if (sclk_fall) begin
        rx_sh_r <= rx_full;
        if (bit_cnt_r == wbits - 6'h01) begin
          bit_cnt_r <= 6'h00;
          if (word_idx_r != `ACS_IDX_MAX) begin
            word_idx_r <= word_idx_r + 4'h1;
          end
          if (word_idx_r == `ACS_IDX_RESP) begin
            cmd_r <= rx_shr[15:0];
          end else begin
            rx_word_out       <= rx_shr[15:0];
            rx_word_valid_out <= 1'b1;
          end
          if (word_idx_r == `ACS_IDX_CH_HI) begin
            data_read_out <= 1'b1;
          end
        end else begin
          bit_cnt_r <= bit_cnt_r + 6'h01;
        end
      end
      if (cs_rise && word_idx_r != `ACS_IDX_RESP) begin
        cmd_word_out   <= cmd_r;
        cmd_valid_out  <= 1'b1;
        full_frame_out <= (word_idx_r >= `ACS_FULL_WORDS);
        reset_cmd_out  <= (cmd_r == `ACS_CMD_RESET) &&
                          (word_idx_r >= `ACS_FULL_WORDS);
      end
    end
  end

  assign dout_out    = dout_r;
  assign dout_oe_out = dout_oe_r;

  // ----------------------------------------------------------------------
  // Data-ready source selection
  // ----------------------------------------------------------------------
  reg [1:0]          lag_i;
  reg [1:0]          lead_i;
  reg signed [PW-1:0] ph;
  reg signed [PW-1:0] lag_ph;
  reg signed [PW-1:0] lead_ph;
  reg signed [PW-1:0] ctl_ph;
  reg signed [PW-1:0] bnd;
  reg                ev;
  reg                bnd_ok;
  integer            i;

  always @* begin
    lag_i   = 2'h0;
    lead_i  = 2'h0;
    lag_ph  = {1'b1, {PW-1{1'b0}}};
    lead_ph = {1'b0, {PW-1{1'b1}}};
    ph      = {PW{1'b0}};
    for (i = 0; i < CH; i = i + 1) begin
      ph = channel_phase_setting_in[i*PW +: PW];
      if (channel_enable_in[i] && ph >= lag_ph) begin
        lag_ph = ph;
        lag_i  = i[1:0];
      end
      if (channel_enable_in[i] && ph <= lead_ph) begin
        lead_ph = ph;
        lead_i  = i[1:0];
      end
    end
    bnd_ok = 1'b1;
    case (oversampling_ratio_in)
      `ACS_OSR_128:  bnd = `ACS_BND_128;
      `ACS_OSR_256:  bnd = `ACS_BND_256;
      `ACS_OSR_512:  bnd = `ACS_BND_512;
      `ACS_OSR_1024: bnd = `ACS_BND_1024;
      default: begin
        bnd    = {PW{1'b0}};
        bnd_ok = 1'b0;
      end
    endcase
    if (global_chop_in || ready_source_select_in == `ACS_SRC_ANY) begin
      ev     = |(channel_new_in & channel_enable_in);
      ctl_ph = {PW{1'b0}};
      bnd_ok = 1'b0;
    end else if (ready_source_select_in == `ACS_SRC_LAG) begin
      ev     = channel_new_in[lag_i] & channel_enable_in[lag_i];
      ctl_ph = lag_ph;
    end else begin
      ev     = channel_new_in[lead_i] & channel_enable_in[lead_i];
      ctl_ph = lead_ph;
    end
  end

  // ----------------------------------------------------------------------
  // Data-ready pin
  // ----------------------------------------------------------------------
  reg [CH-1:0] en_prev_r;
  reg          first_r;
  reg          data_ready_n_n_r;
  reg          gap_r;
  reg          unread_r;
  reg [2:0]    pulse_r;
  wire         skip_first = first_r & bnd_ok & (ctl_ph <= bnd);
  wire         ev_ok = ev & ~skip_first;

  always @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      en_prev_r <= {CH{1'b0}};
      first_r   <= 1'b0;
      data_ready_n_n_r  <= 1'b1;
      gap_r     <= 1'b0;
      unread_r  <= 1'b0;
      pulse_r   <= 3'h0;
    end else begin
      en_prev_r <= channel_enable_in;
      if (ev) begin
        first_r <= 1'b0;
      end
      if (sync_in || |(channel_enable_in & ~en_prev_r)) begin
        first_r <= 1'b1;
      end
      if (ready_format_select_in) begin
        gap_r <= 1'b0;
        if (pulse_r != 3'h0) begin
          pulse_r <= pulse_r - 3'h1;
          if (pulse_r == 3'h1) begin
            data_ready_n_n_r <= 1'b1;
          end
        end
        if (data_read_out) begin
          unread_r <= 1'b0;
        end
        // An unread result drops the next event; the set wins a same-cycle read.
        if (ev_ok) begin
          if (unread_r && !data_read_out) begin
            unread_r <= 1'b0;
          end else begin
            data_ready_n_n_r <= 1'b0;
            pulse_r  <= `ACS_PULSE_CYC;
            unread_r <= 1'b1;
          end
        end
      end else begin
        pulse_r  <= 3'h0;
        unread_r <= 1'b0;
        if (ev_ok) begin
          data_ready_n_n_r <= ~data_ready_n_n_r;
          gap_r    <= ~data_ready_n_n_r;
        end else if (gap_r) begin
          data_ready_n_n_r <= 1'b0;
          gap_r    <= 1'b0;
        end else if (data_read_out) begin
          data_ready_n_n_r <= 1'b1;
        end
      end
    end
  end

  // Open-drain mode never drives high; the board pull-up supplies the level.
  assign data_ready_n_out    = ready_drive_select_in ? 1'b0 : data_ready_n_n_r;
  assign data_ready_n_oe_out = ~ready_drive_select_in | ~data_ready_n_n_r;
endmodule // acs_frame_ready

// [design/acs_consts.vh]
// Constants and behaviour summary for the converter serial frame block.
// Behaviour
// - With chip select low, shift responses and data out on serial clock rise.
// - Serial output is released (enable low) whenever chip select is high.
// - Data-ready gives one falling edge per output data period.
// - Source 00b follows the most lagging (largest phase) enabled channel.
// - Source 01b asserts data-ready whenever any enabled channel has new data.
// - Source 10b or 11b follows the most leading (smallest phase) channel.
// - In global-chop mode the source select has no effect.
// - First assertion after enable or sync skips a period at or below the boundary.
// - Drive bit 0b drives high push-pull, 1b releases like open drain.
// - Format 0b: low on new data until data read, brief high otherwise.
// - Format 1b: short low pulse, unread result makes next one skipped.
// - Word length is 16, 24 or 32 bits, 24 after reset.
// - Command, response, CRC, register words are 16 bits MSB aligned.
// - Conversion words are zero padded, or sign extended in 32-bit sign mode (11b).
// - First output word carries the response to the previous command.
// - Device sends response, three channel words, then the CRC word.
// - Disabled channels keep their slot and read all zeros.
// - Multi-register reads and writes lengthen the frame with extra words.
// - Short frames only when converters are disabled.
// - Reset command acts only when carried in a full frame.
// - Link runs in SPI mode 1, idle low, change rise, sample fall.
// - Chip select high resets the interface and traffic is ignored.
// - Serial input bits are captured on falling serial clock edges.
`ifndef ACS_CONSTS_VH
`define ACS_CONSTS_VH
// ----------------------------------------------------------------------
// Word length encodings
// ----------------------------------------------------------------------
`define ACS_WL_16      2'h0
`define ACS_WL_24      2'h1
`define ACS_WL_32_ZERO 2'h2
`define ACS_WL_32_SIGN 2'h3
`define ACS_WL_RESET   2'h1
`define ACS_BITS_16    6'h10
`define ACS_BITS_24    6'h18
`define ACS_BITS_32    6'h20
// ----------------------------------------------------------------------
// Ready source encodings
// ----------------------------------------------------------------------
`define ACS_SRC_LAG    2'h0
`define ACS_SRC_ANY    2'h1
// ----------------------------------------------------------------------
// Frame layout, word indices
// ----------------------------------------------------------------------
`define ACS_IDX_RESP   4'h0
`define ACS_IDX_CH_LO  4'h1
`define ACS_IDX_CH_HI  4'h3
`define ACS_IDX_CRC    4'h4
`define ACS_FULL_WORDS 4'h5
`define ACS_IDX_MAX    4'hf
`define ACS_CMD_RESET  16'h0011
`define ACS_PAD16      16'h0000
// ----------------------------------------------------------------------
// Oversampling codes and first-assertion phase boundaries
// ----------------------------------------------------------------------
`define ACS_OSR_128    3'h0
`define ACS_OSR_256    3'h1
`define ACS_OSR_512    3'h2
`define ACS_OSR_1024   3'h3
`define ACS_BND_128    10'h3ed
`define ACS_BND_256    10'h3ad
`define ACS_BND_512    10'h32d
`define ACS_BND_1024   10'h22d
// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define ACS_CLK_NS     4
`define ACS_PULSE_NS   16
`define ACS_PULSE_CYC  3'h4
`define ACS_PIN_IDLE   3'h2
`endif

// [design/acs_buf2.v]
// Two-entry buffer between the converter and the serial frame.
`timescale 1ns/100ps
module acs_buf2 #(
  parameter W = 48
) (
  // Clock and reset
  input  wire         clk_in,
  input  wire         rst_n_in,
  // Filling side
  input  wire         in_valid_in,
  output wire         in_ready_out,
  input  wire [W-1:0] in_data_in,
  // Draining side
  output wire         out_valid_out,
  input  wire         out_ready_in,
  output wire [W-1:0] out_data_out
);
  reg [W-1:0] mem_r [0:1];
  reg         wp_r;
  reg         rp_r;
  reg [1:0]   cnt_r;
  wire        push = in_valid_in & (cnt_r != 2'h2);
  wire        pop  = out_ready_in & (cnt_r != 2'h0);

  assign in_ready_out  = (cnt_r != 2'h2);
  assign out_valid_out = (cnt_r != 2'h0);
  assign out_data_out  = mem_r[rp_r];

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wp_r     <= 1'b0;
      rp_r     <= 1'b0;
      cnt_r    <= 2'h0;
      mem_r[0] <= {W{1'b0}};
      mem_r[1] <= {W{1'b0}};
    end else begin
      if (push) begin
        mem_r[wp_r] <= in_data_in;
        wp_r        <= ~wp_r;
      end
      if (pop) begin
        rp_r <= ~rp_r;
      end
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule // acs_buf2

// [tb/acs_fr_properties.sv]
// Concurrent checks on the converter frame and ready ports.
`timescale 1ns/100ps
module acs_fr_properties #(
  parameter CH = 3
) (
  // Clock and reset
  input wire logic          clk_in,
  input wire logic          resetn_in,
  // Pins
  input wire logic          sclk_in,
  input wire logic          cs_n_in,
  input wire logic          dout_out,
  input wire logic          dout_oe_out,
  input wire logic          data_ready_n_out,
  input wire logic          data_ready_n_oe_out,
  // Control and status
  input wire logic          ready_drive_select_in,
  input wire logic          ready_format_select_in,
  input wire logic [CH-1:0] channel_new_in,
  input wire logic [15:0]   cmd_word_out,
  input wire logic          cmd_valid_out,
  input wire logic          full_frame_out,
  input wire logic          reset_cmd_out,
  input wire logic          data_read_out
);
  // ------
  // Sequences
  // ------
  default clocking dc @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  wire pp = !ready_drive_select_in;
  sequence s_cs_idle; cs_n_in[*8] ##1 cs_n_in[*2]; endsequence
  sequence s_cs_busy; !cs_n_in[*8] ##1 !cs_n_in[*2]; endsequence
  sequence s_short_low; !data_ready_n_out[*4] ##1 data_ready_n_out; endsequence
  // ------
  // Assertions
  // ------
  dout_release_a: assert property (s_cs_idle |-> !dout_oe_out)
    else $error("serial output driven while deselected");
  dout_drive_a: assert property (s_cs_busy |-> dout_oe_out)
    else $error("serial output not driven in frame");
  dout_hold_a: assert property ($fell(sclk_in) && dout_oe_out |->
    $stable(dout_out)[*3]) else $error("serial output moved near fall");
  ready_cause_a: assert property (pp && $fell(data_ready_n_out) |->
    ($past(channel_new_in) != 0 || $past(channel_new_in, 2) != 0))
    else $error("ready fell without new data");
  pulse_width_a: assert property (pp && ready_format_select_in &&
    $fell(data_ready_n_out) |-> s_short_low) else $error("bad pulse width");
  drain_low_a: assert property (ready_drive_select_in &&
    $past(ready_drive_select_in) |-> !data_ready_n_out)
    else $error("open drain level driven high");
  push_pull_a: assert property (pp && $past(pp) |-> data_ready_n_oe_out)
    else $error("push-pull ready not driven");
  reset_full_a: assert property (reset_cmd_out |->
    full_frame_out && cmd_word_out == 16'h0011)
    else $error("reset taken from wrong frame");
  short_frame_a: assert property (cmd_valid_out && !full_frame_out |->
    !reset_cmd_out[*2]) else $error("reset taken from short frame");
  read_release_a: assert property (pp && !ready_format_select_in &&
    data_read_out |-> ##[0:2] data_ready_n_out)
    else $error("ready held low after read");
endmodule // acs_fr_properties

bind acs_frame_ready acs_fr_properties #(.CH(CH)) u_props (
  .clk_in(clk_in), .resetn_in(resetn_in), .sclk_in(sclk_in),
  .cs_n_in(cs_n_in), .dout_out(dout_out), .dout_oe_out(dout_oe_out),
  .data_ready_n_out(data_ready_n_out),
  .data_ready_n_oe_out(data_ready_n_oe_out),
  .ready_drive_select_in(ready_drive_select_in),
  .ready_format_select_in(ready_format_select_in),
  .channel_new_in(channel_new_in), .cmd_word_out(cmd_word_out),
  .cmd_valid_out(cmd_valid_out), .full_frame_out(full_frame_out),
  .reset_cmd_out(reset_cmd_out), .data_read_out(data_read_out));

// [tb/acs_host_model.sv]
// Behavioural serial host that frames words to the converter block.
`timescale 1ns/100ps
module acs_host_model (
  // Serial pins
  output logic      sclk_out,
  output logic      cs_n_out,
  output logic      din_out,
  input  wire logic dout_in,
  input  wire logic dout_oe_in
);
  logic [31:0] rx_w [0:15];
  int          nw_seen;
  event        done_ev;
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    din_out  = 1'b0;
  end
  // ------
  // Frame
  // ------
  // The clock only runs while selected; an unlucky phase offset is on purpose.
  task automatic frame(input int nw, input int nb, input logic [15:0] cmd);
    logic [31:0] tx;
    #13.7;
    cs_n_out = 1'b0;
    #64;
    for (int w = 0; w < nw; w++) begin
      tx = (w == 0) ? {cmd, 16'h0000} : 32'h0000_0000;
      rx_w[w] = 32'h0000_0000;
      for (int b = 0; b < nb; b++) begin
        sclk_out = 1'b1;
        din_out  = tx[31-b];
        #32;
        sclk_out = 1'b0;
        rx_w[w] = {rx_w[w][30:0], dout_oe_in ? dout_in : 1'bx};
        #32;
      end
    end
    #64;
    cs_n_out = 1'b1;
    din_out  = ~din_out;
    nw_seen  = nw;
    ->done_ev;
    #64;
  endtask
endmodule // acs_host_model

// [tb/acs_frame_ready_tb_top.sv]
// Self-checking bench for the converter frame and ready block.
`timescale 1ns/100ps
module acs_frame_ready_tb_top;
  logic        clk_in = 1'b0;
  logic        resetn_in = 1'b0;
  logic [1:0]  wl = 2'h1;
  logic [1:0]  src = 2'h0;
  logic        drv = 1'b0;
  logic        fmt = 1'b0;
  logic        gc = 1'b0;
  logic        sync = 1'b0;
  logic        cv = 1'b0;
  logic [2:0]  oversampling_ratio = 3'h0;
  logic [2:0]  en = 3'h7;
  logic [2:0]  cnew = 3'h0;
  logic [29:0] ph = {10'h000, 10'h3f6, 10'h005};
  logic [47:0] cdat = 48'h0000_0000_0000;
  logic [15:0] resp = 16'h0000;
  logic [15:0] crc = 16'h0000;
  logic [15:0] regw = 16'h0000;
  logic [9:0]  bnd [0:4] = '{10'h3ed, 10'h3ad, 10'h32d, 10'h22d, 10'h22d};
  wire         sclk, cs_n, din, dout, dout_oe, data_ready_n_n, data_ready_n_oe, crdy;
  wire         cmd_v, full, rst_cmd, rd, rxv;
  wire  [15:0] cmd_w, rxw;
  wire         data_ready_n_pin = data_ready_n_oe ? data_ready_n_n : 1'b1;
  logic [31:0] wq[$];
  logic [31:0] dq[$];
  logic [17:0] cq[$];
  logic [47:0] bq[$];
  logic [17:0] got;
  int          n_fail = 0;
  int          checks = 0;
  int          falls = 0;
  int          f0;
  always #2 clk_in = ~clk_in;
  acs_frame_ready dut (
    .clk_in(clk_in), .resetn_in(resetn_in), .sclk_in(sclk), .cs_n_in(cs_n),
    .din_in(din), .dout_out(dout), .dout_oe_out(dout_oe),
    .data_ready_n_out(data_ready_n_n), .data_ready_n_oe_out(data_ready_n_oe),
    .word_length_select_in(wl), .ready_source_select_in(src),
    .ready_drive_select_in(drv), .ready_format_select_in(fmt),
    .global_chop_in(gc), .oversampling_ratio_in(oversampling_ratio),
    .channel_enable_in(en), .channel_phase_setting_in(ph), .sync_in(sync),
    .channel_new_in(cnew), .conv_valid_in(cv), .conv_ready_out(crdy),
    .conv_data_in(cdat), .response_in(resp), .crc_in(crc),
    .reg_word_in(regw), .word_index_out(), .rx_word_out(rxw),
    .rx_word_valid_out(rxv), .cmd_word_out(cmd_w), .cmd_valid_out(cmd_v),
    .full_frame_out(full), .reset_cmd_out(rst_cmd), .data_read_out(rd));
  acs_host_model host (.sclk_out(sclk), .cs_n_out(cs_n), .din_out(din),
    .dout_in(dout), .dout_oe_in(dout_oe));
  // ------
  // Checking
  // ------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  function automatic logic [31:0] w16(input logic [15:0] v);
    case (wl)
      2'h0: w16 = {16'h0000, v};
      2'h1: w16 = {8'h00, v, 8'h00};
      default: w16 = {v, 16'h0000};
    endcase
  endfunction
  function automatic logic [31:0] wconv(input logic [15:0] v, input logic e);
    if (!e) wconv = 32'h0000_0000;
    else if (wl == 2'h3) wconv = {{16{v[15]}}, v};
    else wconv = w16(v);
  endfunction
  always @(host.done_ev) begin
    for (int i = 0; i < host.nw_seen; i++)
      check(host.rx_w[i], (wq.size() > 0) ? wq.pop_front() : 'x);
  end
  always @(posedge clk_in) begin
    if (cmd_v === 1'b1) begin
      got = {rst_cmd, full, cmd_w};
      @(posedge clk_in);
      got[17] = got[17] | rst_cmd;
      check({14'h0000, got}, {14'h0000, cq.pop_front()});
    end
  end
  always @(negedge data_ready_n_pin) falls++;
  always @(posedge clk_in)
    if (rxv === 1'b1) check({16'h0000, rxw}, 32'h0);
  always @(posedge clk_in) begin
    if (|cnew) begin
      f0 = falls;
      repeat (4) @(posedge clk_in);
      check(32'(falls - f0), (dq.size() > 0) ? dq.pop_front() : 'x);
    end
  end
  // ------
  // Stimulus
  // ------
  task automatic ev(input logic [2:0] m, input logic [31:0] e);
    dq.push_back(e);
    @(negedge clk_in) cnew = m;
    @(negedge clk_in) cnew = 3'h0;
    repeat (8) @(negedge clk_in);
  endtask
  task automatic push(input logic [47:0] d);
    int k;
    k = 0;
    @(negedge clk_in);
    cv = 1'b1;
    cdat = d;
    @(posedge clk_in);
    while (!crdy && k < 64) begin
      k++;
      @(posedge clk_in);
    end
    check({31'h0, crdy}, 32'h1);
    if (crdy) bq.push_back(d);
    @(negedge clk_in) cv = 1'b0;
  endtask
  task automatic xfer(input int nw, input logic [15:0] cmd);
    logic [47:0] d;
    d = (bq.size() > 0) ? bq.pop_front() : 48'h0000_0000_0000;
    @(negedge clk_in);
    resp = 16'($urandom);
    crc = 16'($urandom);
    regw = 16'($urandom);
    for (int i = 0; i < nw; i++)
      wq.push_back(i == 0 ? w16(resp) : i == 4 ? w16(crc) : i > 4 ?
                   w16(regw) : wconv(d[16*(i-1) +: 16], en[i-1]));
    cq.push_back({cmd == 16'h0011 && nw >= 5, nw >= 5, cmd});
    host.frame(nw, (wl == 2'h0) ? 16 : (wl == 2'h1) ? 24 : 32, cmd);
  endtask
  initial begin
    #300000;
    n_fail++;
    complete_run;
  end
  initial begin
    void'($urandom(32'h15f3));
    repeat (16) @(negedge clk_in);
    resetn_in = 1'b1;
    repeat (8) @(negedge clk_in);
    check({31'h0, data_ready_n_pin}, 32'h1);
    check({31'h0, dout_oe}, 32'h0);
    for (int g = 0; g < 2; g++)
      for (int s = 0; s < 4; s++)
        for (int c = 0; c < 3; c++) begin
          gc = g[0];
          src = s[1:0];
          ev(3'h1 << c, 32'(g == 1 || s == 1 || (s == 0 && c == 0) ||
             (s > 1 && c == 1)));
        end
    gc = 1'b0;
    src = 2'h2;
    xfer(5, 16'h0000);
    repeat (4) @(negedge clk_in);
    check({31'h0, data_ready_n_pin}, 32'h1);
    for (int w = 0; w < 4; w++) begin
      @(negedge clk_in);
      wl = w[1:0];
      en = (w == 2) ? 3'h5 : 3'h7;
      push(48'({$urandom, $urandom}));
      xfer(5, 16'($urandom));
    end
    // Fill the buffer while the host stalls, then drain it past empty.
    @(negedge clk_in);
    wl = 2'h1;
    en = 3'h7;
    push(48'({$urandom, $urandom}));
    push(48'({$urandom, $urandom}));
    @(negedge clk_in) cv = 1'b1;
    repeat (4) @(negedge clk_in);
    check({31'h0, crdy}, 32'h0);
    cv = 1'b0;
    xfer(7, 16'h0000);
    xfer(5, 16'h0011);
    xfer(5, 16'h0000);
    @(negedge clk_in) en = 3'h0;
    xfer(2, 16'h0011);
    @(negedge clk_in) en = 3'h7;
    for (int o = 0; o < 5; o++) begin
      @(negedge clk_in);
      oversampling_ratio = o[2:0];
      ph[19:10] = bnd[o];
      for (int p = 0; p < 2; p++) begin
        @(negedge clk_in) sync = 1'b1;
        @(negedge clk_in) sync = 1'b0;
        ev(3'h2, 32'(p == 1 || o == 4));
        ev(3'h2, 32'h1);
        ph[19:10] = bnd[o] + 10'h001;
      end
    end
    src = 2'h1;
    xfer(5, 16'h0000);
    @(negedge clk_in) fmt = 1'b1;
    ev(3'h1, 32'h1);
    ev(3'h1, 32'h0);
    ev(3'h1, 32'h1);
    xfer(5, 16'h0000);
    ev(3'h1, 32'h1);
    @(negedge clk_in);
    fmt = 1'b0;
    drv = 1'b1;
    repeat (2) @(negedge clk_in);
    check({31'h0, data_ready_n_oe}, 32'h0);
    ev(3'h1, 32'h1);
    check({31'h0, data_ready_n_oe}, 32'h1);
    xfer(5, 16'h0000);
    repeat (4) @(negedge clk_in);
    check({31'h0, data_ready_n_oe}, 32'h0);
    complete_run;
  end
endmodule // acs_frame_ready_tb_top
